// ==== inc/dmau_pkg.sv ====
/*
 Package of the data memory access unit: special register offsets, field positions,
 reset values, address map limits and bus cycle timing counts.
 Assumes a CPU core that issues one access at a time on the same clock.
*/
package dmau_pkg;

    // ------------------------------------------------------------
    // Special register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] PTR_HIGH_ADDR = 8'h83;
    localparam logic [7:0] PTR_LOW_ADDR = 8'h84;
    localparam logic [7:0] AUX_CTRL_ADDR = 8'h8E;
    localparam logic [7:0] STATUS_WORD_ADDR = 8'hD0;
    localparam logic [7:0] AUX_CTRL_ONE_ADDR = 8'hA2;
    localparam logic [7:0] PORT_TWO_ADDR = 8'hA0;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int BANK_LOW_BIT = 3;
    localparam int BANK_HIGH_BIT = 4;
    localparam int OFFCHIP_SEL_BIT = 1;
    localparam int SIZE_LSB = 2;
    localparam int STRETCH_BIT = 5;
    localparam int PTR_SEL_BIT = 0;
    localparam logic [7:0] AUX_CTRL_RESET = 8'h14;
    localparam logic [7:0] AUX_CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] STATUS_WORD_RESET = 8'h00;
    localparam logic [7:0] PORT_TWO_RESET = 8'hFF;
    localparam logic [7:0] AUX_CTRL_WMASK = 8'h3F;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam logic [7:0] LOWER_RAM_TOP = 8'h7F;
    localparam logic [7:0] BANK_AREA_TOP = 8'h1F;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [15:0] EXP_RAM_TOP = 16'h07FF;

    // ------------------------------------------------------------
    // Bus cycle timing, in CPU clock periods
    // ------------------------------------------------------------
    localparam int CYCLE_PERIODS = 6;
    localparam int STROBE_NORMAL = 3;
    localparam int STROBE_STRETCH = 15;
    localparam int LATCH_PERIODS = 2;

    // Kind of access issued by the core
    typedef enum logic [1:0] {
        DMAU_DIRECT,
        DMAU_INDIRECT,
        DMAU_EXT_RI,
        DMAU_EXT_PTR
    } dmau_kind_t;

endpackage

// ==== inc/dmau_bus_if.sv ====
/*
 Interface between the access unit and its external bus sequencer.
 Assumes both ends share the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface dmau_bus_if;
    logic start;
    logic write;
    logic stretch;
    logic use_high;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;

    modport ctrl (output start, write, stretch, use_high, addr, wdata, input rdata, done);
    modport seq (input start, write, stretch, use_high, addr, wdata, output rdata, done);
endinterface
`default_nettype wire

// ==== design/dmau_ext_bus.sv ====
/*
 External bus sequencer: one multiplexed bus cycle of six CPU clock periods, eighteen stretched,
 with read and write strobes of three or, stretched, fifteen periods.
 Assumes the CPU clock enable marks CPU clock periods; bus pins are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
module dmau_ext_bus (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Request side
    dmau_bus_if.seq bus,
    // Pins
    input wire logic [7:0] i_p0_in,
    output logic [7:0] o_p0_out,
    output logic o_p0_oe,
    output logic [7:0] o_p2_addr,
    output logic o_p2_oe,
    output logic o_ale,
    output logic o_rd_n,
    output logic o_wr_n
);
    typedef enum logic [1:0] {DMAU_IDLE, DMAU_ADDR, DMAU_STROBE, DMAU_TAIL} dmau_bst_t;

    dmau_bst_t st_q;
    logic [4:0] cnt_q;
    logic [7:0] p0_s1_q, p0_s2_q;
    logic wr_q;
    logic [4:0] strobe_len;

    // Strobe width picked at the start of the strobe phase
    assign strobe_len = bus.stretch ? 5'(dmau_pkg::STROBE_STRETCH)
                                    : 5'(dmau_pkg::STROBE_NORMAL);

    // Two-stage sampling of port zero, read data comes from the second stage only
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            p0_s1_q <= 8'h00;
            p0_s2_q <= 8'h00;
        end else if (i_ce) begin
            p0_s1_q <= i_p0_in;
            p0_s2_q <= p0_s1_q;
        end
    end

    // Phase sequencer: latch, strobe, tail add up to six periods unstretched
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            st_q <= DMAU_IDLE;
            cnt_q <= 5'h00;
            wr_q <= 1'b0;
            o_ale <= 1'b0;
            o_rd_n <= 1'b1;
            o_wr_n <= 1'b1;
            o_p0_oe <= 1'b0;
            o_p0_out <= 8'h00;
            o_p2_oe <= 1'b0;
            o_p2_addr <= 8'h00;
            bus.rdata <= 8'h00;
            bus.done <= 1'b0;
        end else if (i_ce) begin
            bus.done <= 1'b0;
            case (st_q)
                DMAU_IDLE: begin
                    if (bus.start) begin
                        st_q <= DMAU_ADDR;
                        cnt_q <= 5'(dmau_pkg::LATCH_PERIODS - 1);
                        wr_q <= bus.write;
                        o_ale <= 1'b1;
                        o_p0_out <= bus.addr[7:0];
                        o_p0_oe <= 1'b1;
                        o_p2_addr <= bus.addr[15:8];
                        o_p2_oe <= 1'b1;
                    end
                end
                DMAU_ADDR: begin
                    if (cnt_q == 5'h00) begin
                        o_ale <= 1'b0;
                        st_q <= DMAU_STROBE;
                        cnt_q <= strobe_len - 5'h01;
                        o_rd_n <= wr_q;
                        o_wr_n <= ~wr_q;
                        o_p0_oe <= wr_q;
                        o_p0_out <= wr_q ? bus.wdata : 8'h00;
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                DMAU_STROBE: begin
                    if (cnt_q == 5'h00) begin
                        o_rd_n <= 1'b1;
                        o_wr_n <= 1'b1;
                        bus.rdata <= p0_s2_q;
                        st_q <= DMAU_TAIL;
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                DMAU_TAIL: begin
                    // One closing period completes the six- or, stretched, eighteen-period cycle
                    o_p0_oe <= 1'b0;
                    o_p2_oe <= 1'b0;
                    bus.done <= 1'b1;
                    st_q <= DMAU_IDLE;
                end
                default: st_q <= DMAU_IDLE;
            endcase
        end
    end
endmodule // dmau_ext_bus
`default_nettype wire

// ==== design/dmau_ram.sv ====
/*
 Byte storage in flip-flops, addressed by an index.
 Assumes one access per enabled clock; contents are not cleared.
*/
`timescale 1ns/1ns
`default_nettype none
module dmau_ram #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    // Clock and enable
    input wire logic i_clk,
    input wire logic i_ce,
    // Access
    input wire logic i_we,
    input wire logic [AW-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    logic [7:0] mem_q [DEPTH];

    // No reset on contents: software must initialise before use
    always_ff @(posedge i_clk) begin
        if (i_ce && i_we) begin
            mem_q[i_addr] <= i_wdata;
        end
    end

    // Read data registered
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            o_rdata <= mem_q[i_addr];
        end
    end
endmodule // dmau_ram
`default_nettype wire

// ==== design/dmau_top.sv ====
/*
 Data memory access unit: internal RAM decode with banks and bit area,
 special register decode for the pointer and control registers, expansion RAM
 versus external bus selection, and two switchable data pointers.
 Assumes the CPU core issues one access at a time and holds it until o_ACK.
*/
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Lower RAM 00h-7Fh reachable by direct and indirect addressing.
// - Lowest 32 bytes form four banks of eight working registers.
// - Two bank-select bits pick bank base 00h, 08h, 10h or 18h.
// - Sixteen bytes above banks are bit addressable, bits 00h-7Fh.
// - Upper RAM 80h-FFh reachable only by indirect addressing.
// - Direct addresses 80h-FFh go to special register space.
// - 2048-byte expansion RAM at 0000h-07FFh, external moves only.
// - Off-chip select 0 routes to expansion RAM, 1 to external; default 0.
// - Three-bit size field sets accessible expansion RAM size, default 2048.
// - Size codes 256,512,768,1024,1792,2048; reset 101; 110/111 reserved.
// - RAM contents undefined at power-up; software initialises them.
// - Address latch strobe high while low address is valid.
// - Active-low read strobe on P3.7, write strobe on P3.6.
// - Each external memory cycle lasts six CPU clock periods; stretched cycles here last 18.
// - Stretch bit widens strobes from 3 to 15 CPU clock periods.
// - Eight-bit indirect external move leaves port two showing its port register.
// - Two 16-bit pointers seen at 83h/84h, selected by pointer-select bit.
// - Incrementing the auxiliary register toggles the pointer-select bit.
// - Pointer-select bit sits at bit 0 of register A2h.
module dmau_top (
    // Clock, reset, enable
    input wire logic I_SYS_CLK,
    input wire logic I_NRST,
    input wire logic I_CE,
    // Core access request
    input wire logic I_REQ,
    input wire logic [1:0] I_KIND,
    input wire logic I_WRITE,
    input wire logic I_BIT_OP,
    input wire logic I_INC_OP,
    input wire logic I_BANK_REG,
    input wire logic [15:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    // Core answer
    output logic O_ACK,
    output logic [7:0] O_RDATA,
    output logic [15:0] O_ACTIVE_PTR,
    // External bus pins
    input wire logic [7:0] I_P0,
    output logic [7:0] O_P0,
    output logic O_P0_OE,
    output logic [7:0] O_P2,
    output logic O_P2_OE,
    output logic O_ALE,
    output logic O_RD_N,
    output logic O_WR_N
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DMAU_S_IDLE, DMAU_S_RAM, DMAU_S_EXP, DMAU_S_EXT, DMAU_S_ACK
    } dmau_st_t;

    dmau_st_t st_q;
    logic [7:0] aux_ctrl_q;
    logic [7:0] aux_one_q;
    logic [7:0] status_word_q;
    logic [7:0] port_two_q;
    logic [15:0] ptr0_q, ptr1_q;
    logic [7:0] rdata_q;
    logic ack_q;
    logic [2:0] bit_sel_q;
    logic bit_op_q, write_q;
    logic merge_q;
    logic [7:0] bit_wbyte_q;

    logic ptr_sel;
    logic [15:0] active_ptr;
    dmau_pkg::dmau_kind_t kind;
    logic [7:0] ram_addr;
    logic [15:0] ext_addr;
    logic [11:0] exp_size;
    logic exp_hit;
    logic is_sfr;
    logic [7:0] sfr_rdata;
    logic ram_we, exp_we;
    logic [7:0] ram_rdata, exp_rdata;
    logic [7:0] ram_wdata;

    dmau_bus_if bus ();

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign ptr_sel = aux_one_q[dmau_pkg::PTR_SEL_BIT];
    assign active_ptr = ptr_sel ? ptr1_q : ptr0_q;
    assign O_ACTIVE_PTR = active_ptr;
    // Core encoding of the access kind matches the package enum
    assign kind = dmau_pkg::dmau_kind_t'(I_KIND);

    // Direct access at 80h and above is special register space, never upper RAM
    assign is_sfr = (kind == dmau_pkg::DMAU_DIRECT) && !I_BIT_OP
                    && (I_ADDR[7:0] > dmau_pkg::LOWER_RAM_TOP);

    // Internal RAM index: bank registers, bit area, or plain byte address
    always_comb begin
        ram_addr = I_ADDR[7:0];
        if (I_BANK_REG) begin
            ram_addr = {3'b000, status_word_q[dmau_pkg::BANK_HIGH_BIT],
                        status_word_q[dmau_pkg::BANK_LOW_BIT], I_ADDR[2:0]};
        end else if (I_BIT_OP) begin
            ram_addr = dmau_pkg::BIT_AREA_BASE + {4'h0, I_ADDR[6:3]};
        end
    end

    // External address: pointer moves use the active pointer, register moves one byte
    assign ext_addr = (kind == dmau_pkg::DMAU_EXT_PTR) ? active_ptr
                                                        : {port_two_q, I_ADDR[7:0]};

    // Accessible expansion size in bytes minus one
    always_comb begin
        case (aux_ctrl_q[dmau_pkg::SIZE_LSB +: 3])
            3'b000: exp_size = 12'h0FF;
            3'b001: exp_size = 12'h1FF;
            3'b010: exp_size = 12'h2FF;
            3'b011: exp_size = 12'h3FF;
            3'b100: exp_size = 12'h6FF;
            3'b101: exp_size = 12'h7FF;
            default: exp_size = 12'h7FF; // Reserved codes keep the full size
        endcase
    end

    // Expansion RAM only for external moves, select bit low, and inside size
    assign exp_hit = !aux_ctrl_q[dmau_pkg::OFFCHIP_SEL_BIT]
                     && (ext_addr <= dmau_pkg::EXP_RAM_TOP)
                     && (ext_addr[11:0] <= exp_size);

    // ------------------------------------------------------------
    // Special register read mux
    // ------------------------------------------------------------
    always_comb begin
        case (I_ADDR[7:0])
            dmau_pkg::PTR_HIGH_ADDR: sfr_rdata = active_ptr[15:8];
            dmau_pkg::PTR_LOW_ADDR: sfr_rdata = active_ptr[7:0];
            dmau_pkg::AUX_CTRL_ADDR: sfr_rdata = aux_ctrl_q & dmau_pkg::AUX_CTRL_WMASK;
            dmau_pkg::AUX_CTRL_ONE_ADDR: sfr_rdata = aux_one_q;
            dmau_pkg::STATUS_WORD_ADDR: sfr_rdata = status_word_q;
            dmau_pkg::PORT_TWO_ADDR: sfr_rdata = port_two_q;
            default: sfr_rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    assign ram_we = (st_q == DMAU_S_RAM) && write_q && (!bit_op_q || merge_q);
    assign exp_we = I_CE && I_REQ && (st_q == DMAU_S_IDLE) && I_WRITE
                    && I_KIND[1] && exp_hit;
    // Bit writes merge the single bit into the byte read beforehand
    assign ram_wdata = bit_op_q ? bit_wbyte_q : I_WDATA;

    dmau_ram #(.DEPTH(256), .AW(8)) u_int_ram (
        .i_clk(I_SYS_CLK),
        .i_ce(I_CE),
        .i_we(ram_we),
        .i_addr(ram_addr),
        .i_wdata(ram_wdata),
        .o_rdata(ram_rdata)
    );

    dmau_ram #(.DEPTH(2048), .AW(11)) u_exp_ram (
        .i_clk(I_SYS_CLK),
        .i_ce(I_CE),
        .i_we(exp_we),
        .i_addr(ext_addr[10:0]),
        .i_wdata(I_WDATA),
        .o_rdata(exp_rdata)
    );

    dmau_ext_bus u_ext_bus (
        .i_clk(I_SYS_CLK),
        .i_nrst(I_NRST),
        .i_ce(I_CE),
        .bus(bus.seq),
        .i_p0_in(I_P0),
        .o_p0_out(O_P0),
        .o_p0_oe(O_P0_OE),
        .o_p2_addr(O_P2),
        .o_p2_oe(O_P2_OE),
        .o_ale(O_ALE),
        .o_rd_n(O_RD_N),
        .o_wr_n(O_WR_N)
    );

    // Bus request fields
    assign bus.start = (st_q == DMAU_S_EXT) && !bus.done && !ack_q;
    assign bus.write = write_q;
    assign bus.stretch = aux_ctrl_q[dmau_pkg::STRETCH_BIT];
    assign bus.use_high = 1'b1;
    assign bus.addr = ext_addr;
    assign bus.wdata = I_WDATA;

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            st_q <= DMAU_S_IDLE;
            write_q <= 1'b0;
            bit_op_q <= 1'b0;
            merge_q <= 1'b0;
            bit_sel_q <= 3'h0;
            bit_wbyte_q <= 8'h00;
            rdata_q <= 8'h00;
            ack_q <= 1'b0;
        end else if (I_CE) begin
            ack_q <= 1'b0;
            case (st_q)
                DMAU_S_IDLE: begin
                    if (I_REQ) begin
                        write_q <= I_WRITE;
                        bit_op_q <= I_BIT_OP;
                        bit_sel_q <= I_ADDR[2:0];
                        merge_q <= 1'b0;
                        if (I_KIND[1]) begin
                            st_q <= exp_hit ? DMAU_S_EXP : DMAU_S_EXT;
                        end else if (is_sfr) begin
                            rdata_q <= sfr_rdata;
                            ack_q <= 1'b1;
                            st_q <= DMAU_S_ACK;
                        end else begin
                            // Bit writes read first, then write the merged byte
                            st_q <= DMAU_S_RAM;
                        end
                    end
                end
                DMAU_S_RAM: begin
                    if (bit_op_q && write_q && !merge_q) begin
                        bit_wbyte_q <= ram_rdata;
                        bit_wbyte_q[bit_sel_q] <= I_WDATA[0];
                        merge_q <= 1'b1;
                    end else begin
                        rdata_q <= bit_op_q ? {7'h00, ram_rdata[bit_sel_q]} : ram_rdata;
                        ack_q <= 1'b1;
                        st_q <= DMAU_S_ACK;
                    end
                end
                DMAU_S_EXP: begin
                    rdata_q <= exp_rdata;
                    ack_q <= 1'b1;
                    st_q <= DMAU_S_ACK;
                end
                DMAU_S_EXT: begin
                    if (bus.done) begin
                        rdata_q <= bus.rdata;
                        ack_q <= 1'b1;
                        st_q <= DMAU_S_ACK;
                    end
                end
                DMAU_S_ACK: begin
                    // Stay here until the request drops so a held request is not taken twice
                    if (!I_REQ) begin
                        st_q <= DMAU_S_IDLE;
                    end
                end
                default: st_q <= DMAU_S_IDLE;
            endcase
        end
    end

    assign O_ACK = ack_q;
    assign O_RDATA = rdata_q;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Direct writes to special space; an increment of A2h toggles the select
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            aux_ctrl_q <= dmau_pkg::AUX_CTRL_RESET;
            aux_one_q <= dmau_pkg::AUX_CTRL_ONE_RESET;
            status_word_q <= dmau_pkg::STATUS_WORD_RESET;
            port_two_q <= dmau_pkg::PORT_TWO_RESET;
        end else if (I_CE && I_REQ && (st_q == DMAU_S_IDLE) && is_sfr && I_WRITE) begin
            case (I_ADDR[7:0])
                dmau_pkg::AUX_CTRL_ADDR: aux_ctrl_q <= I_WDATA & dmau_pkg::AUX_CTRL_WMASK;
                dmau_pkg::AUX_CTRL_ONE_ADDR: begin
                    if (I_INC_OP) begin
                        aux_one_q[dmau_pkg::PTR_SEL_BIT] <= ~ptr_sel;
                    end else begin
                        aux_one_q <= I_WDATA;
                    end
                end
                dmau_pkg::STATUS_WORD_ADDR: status_word_q <= I_WDATA;
                dmau_pkg::PORT_TWO_ADDR: port_two_q <= I_WDATA;
                default: ;
            endcase
        end
    end

    // Data pointers: only the selected one is written through 83h/84h
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            ptr0_q <= 16'h0000;
            ptr1_q <= 16'h0000;
        end else if (I_CE && I_REQ && (st_q == DMAU_S_IDLE) && is_sfr && I_WRITE) begin
            if (I_ADDR[7:0] == dmau_pkg::PTR_HIGH_ADDR) begin
                if (ptr_sel) ptr1_q[15:8] <= I_WDATA;
                else ptr0_q[15:8] <= I_WDATA;
            end else if (I_ADDR[7:0] == dmau_pkg::PTR_LOW_ADDR) begin
                if (ptr_sel) ptr1_q[7:0] <= I_WDATA;
                else ptr0_q[7:0] <= I_WDATA;
            end
        end
    end
endmodule // dmau_top
`default_nettype wire

// ==== tb/dmau_top_properties.sv ====
/* Pin checker of the access unit.
   Assumes a bind to dmau_top, one clock, reset active low. */
`timescale 1ns/1ns
`default_nettype none
module dmau_props (
    // Watched pins
    input wire logic I_SYS_CLK,
    input wire logic I_NRST,
    input wire logic O_ACK,
    input wire logic O_ALE,
    input wire logic O_RD_N,
    input wire logic O_WR_N,
    input wire logic O_P0_OE
);
    // ------------------------------------------------------------
    // Bus cycle shape
    // ------------------------------------------------------------
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_NRST);
    sequence s_rd_low; !O_RD_N [*3]; endsequence
    sequence s_wr_low; !O_WR_N [*3]; endsequence
    property p_rd_width; $fell(O_RD_N) |-> s_rd_low; endproperty
    a_rd_width: assert property (p_rd_width) else $error("read strobe short");
    property p_rd_end; $fell(O_RD_N) |-> ##[3:15] $rose(O_RD_N); endproperty
    a_rd_end: assert property (p_rd_end) else $error("read strobe length");
    property p_wr_width; $fell(O_WR_N) |-> s_wr_low; endproperty
    a_wr_width: assert property (p_wr_width) else $error("write strobe short");
    property p_ale_first; $fell(O_RD_N) || $fell(O_WR_N) |-> $past(O_ALE); endproperty
    a_ale_first: assert property (p_ale_first) else $error("no latch before strobe");
    property p_ale_idle; O_ALE |-> O_RD_N && O_WR_N; endproperty
    a_ale_idle: assert property (p_ale_idle) else $error("strobe during latch");
    property p_one_strobe; !(!O_RD_N && !O_WR_N); endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
    property p_rd_float; !O_RD_N |-> !O_P0_OE; endproperty
    a_rd_float: assert property (p_rd_float) else $error("port zero driven in read");
    property p_wr_drive; !O_WR_N |-> O_P0_OE; endproperty
    a_wr_drive: assert property (p_wr_drive) else $error("port zero idle in write");
    property p_ack_after; $rose(O_RD_N) |-> ##[1:3] O_ACK; endproperty
    a_ack_after: assert property (p_ack_after) else $error("no answer after read");
endmodule // dmau_props
bind dmau_top dmau_props i_props (.I_SYS_CLK, .I_NRST, .O_ACK, .O_ALE, .O_RD_N, .O_WR_N,
    .O_P0_OE);
`default_nettype wire

// ==== tb/dmau_xmem.sv ====
/* Off-chip data memory on the multiplexed bus.
   Assumes the bench resolves port zero from both drivers. */
`timescale 1ns/1ns
`default_nettype none
module dmau_xmem (
    // Bus pins
    input wire logic i_clk,
    input wire logic i_ale,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [7:0] i_p0,
    input wire logic [7:0] i_p2,
    output logic [7:0] o_p0
);
    logic [7:0] mem [0:65535];
    logic [7:0] lat = 8'h00;
    logic [7:0] last = 8'h00;
    // Low address taken while the latch strobe is high
    always @(posedge i_clk) begin
        if (i_ale) lat <= i_p0;
        if (!i_wr_n) mem[{i_p2, lat}] <= i_p0;
        if (!i_rd_n) last <= o_p0;
    end
    // Released lines show the inverse, so a stale hold cannot pass
    assign o_p0 = !i_rd_n ? mem[{i_p2, lat}] : ~last;
endmodule // dmau_xmem
`default_nettype wire

// ==== tb/test_data_memory_access_unit.sv ====
/* Bench of the access unit against an integer model.
   Assumes dmau_top, dmau_xmem and the pin checker. */
`timescale 1ns/1ns
`default_nettype none
module test_data_memory_access_unit;
    logic clk = 1'b0, nrst = 1'b0, req = 1'b0, wr = 1'b0, bitop = 1'b0, inc = 1'b0;
    logic bank = 1'b0, ack, ale, rd_n, wr_n, p0_oe, p2_oe;
    logic [1:0] kind = 2'h0;
    logic [15:0] addr = 16'h0000, aptr;
    logic [7:0] wd = 8'h00, p0_in, xm_p0, rdata, p0, p2, got, p2_seen;
    int fail_count = 0, checks = 0, lows, ales, a, d, b;
    int ram [256];
    int sz [8] = '{256, 512, 768, 1024, 1792, 2048, 2048, 2048};
    assign p0_in = p0_oe ? p0 : xm_p0;
    dmau_top i_dut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_CE(1'b1), .I_REQ(req), .I_KIND(kind),
        .I_WRITE(wr), .I_BIT_OP(bitop), .I_INC_OP(inc), .I_BANK_REG(bank), .I_ADDR(addr),
        .I_WDATA(wd), .O_ACK(ack), .O_RDATA(rdata), .O_ACTIVE_PTR(aptr), .I_P0(p0_in),
        .O_P0(p0), .O_P0_OE(p0_oe), .O_P2(p2), .O_P2_OE(p2_oe), .O_ALE(ale), .O_RD_N(rd_n),
        .O_WR_N(wr_n));
    dmau_xmem i_xm (.i_clk(clk), .i_ale(ale), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_p0(p0_in),
        .i_p2(p2), .o_p0(xm_p0));
    // Free running clock
    initial forever #20 clk = ~clk;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One request held until answered; strobe and latch cycles counted
    task automatic acc(input logic [1:0] k, input logic w, input logic [15:0] ad,
        input logic [7:0] dat, input logic bo = 1'b0, input logic bk = 1'b0,
        input logic ic = 1'b0);
        int n;
        @(negedge clk);
        {kind, wr, addr, wd, bitop, bank, inc, req} = {k, w, ad, dat, bo, bk, ic, 1'b1};
        {lows, ales, n} = 0;
        do begin
            @(posedge clk);
            #1;
            lows += int'(!rd_n || !wr_n);
            if (ale) p2_seen = p2_oe ? p2 : 8'h00;
            ales += int'(ale);
            n++;
        end while (ack !== 1'b1 && n < 200);
        if (n >= 200) begin
            fail_count++;
            give_verdict();
        end
        got = rdata;
        @(negedge clk);
        req = 1'b0;
    endtask
    task automatic px(input logic w, input logic [15:0] ad, input logic [7:0] dat);
        acc(2'h0, 1'b1, 16'h0083, ad[15:8]);
        acc(2'h0, 1'b1, 16'h0084, ad[7:0]);
        acc(2'h3, w, ad, dat);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        d = $urandom(32'h0FFF);
        repeat (4) @(posedge clk);
        @(negedge clk) nrst = 1'b1;
        chk("ptr_rst", 16'h0000, aptr);
        for (b = 0; b < 4; b++) begin
            acc(2'h0, 1'b1, {8'h00, dmau_pkg::STATUS_WORD_ADDR}, 8'(b << 3));
            ram[b * 8 + 5] = $urandom % 256;
            acc(2'h0, 1'b1, 16'h0005, 8'(ram[b * 8 + 5]), 1'b0, 1'b1);
            acc(2'h0, 1'b0, 16'(b * 8 + 5), 8'h00);
            chk("bank", 16'(ram[b * 8 + 5]), {8'h00, got});
        end
        a = 32 + $urandom % 96;
        d = $urandom % 256;
        acc(2'h0, 1'b1, 16'(a), 8'(d));
        acc(2'h1, 1'b0, 16'(a), 8'h00);
        chk("lower", 16'(d), {8'h00, got});
        b = $urandom % 128;
        acc(2'h0, 1'b1, 16'(32 + b / 8), 8'h00);
        acc(2'h0, 1'b1, 16'(b), 8'h01, 1'b1);
        acc(2'h0, 1'b0, 16'(32 + b / 8), 8'h00);
        chk("bit", 16'(1 << (b % 8)), {8'h00, got});
        px(1'b1, 16'h07FF, 8'(d));
        acc(2'h1, 1'b1, 16'h0083, 8'h5A);
        acc(2'h1, 1'b0, 16'h0083, 8'h00);
        chk("upper", 16'h005A, {8'h00, got});
        acc(2'h0, 1'b0, 16'h0083, 8'h00);
        chk("special", 16'h0007, {8'h00, got});
        acc(2'h0, 1'b1, {8'h00, dmau_pkg::AUX_CTRL_ONE_ADDR}, 8'h00, 1'b0, 1'b0, 1'b1);
        acc(2'h0, 1'b0, {8'h00, dmau_pkg::AUX_CTRL_ONE_ADDR}, 8'h00);
        chk("sel", 16'h0001, {15'h0000, got[0]});
        px(1'b0, 16'h0100, 8'h00);
        acc(2'h0, 1'b1, {8'h00, dmau_pkg::AUX_CTRL_ONE_ADDR}, 8'h00, 1'b0, 1'b0, 1'b1);
        chk("ptr_swap", 16'h07FF, aptr);
        acc(2'h3, 1'b0, 16'h07FF, 8'h00);
        chk("onchip_expansion_ram", 16'(d), {8'h00, got});
        chk("onchip_expansion_ram_bus", 16'h0000, 16'(ales));
        acc(2'h0, 1'b1, 16'h008E, 8'h16);
        acc(2'h3, 1'b1, 16'h07FF, 8'h3C);
        chk("wr_len", 16'h0003, 16'(lows));
        chk("p2", 16'h0007, {8'h00, p2_seen});
        acc(2'h0, 1'b1, 16'h008E, 8'h36);
        acc(2'h3, 1'b0, 16'h07FF, 8'h00);
        chk("stretch", 16'h000F, 16'(lows));
        chk("offchip_data_ram", 16'h003C, {8'h00, got});
        acc(2'h2, 1'b1, 16'h0040, 8'h77);
        chk("p2_ri", 16'h00FF, {8'h00, p2_seen});
        for (b = 0; b < 8; b++) begin
            acc(2'h0, 1'b1, 16'h008E, 8'(b << 2));
            px(1'b1, 16'(sz[b] - 1), 8'h11);
            chk("in_size", 16'h0000, 16'(ales));
            px(1'b1, 16'(sz[b]), 8'h22);
            chk("past_size", 16'h0001, 16'(ales > 0));
        end
        give_verdict();
    end
endmodule // test_data_memory_access_unit
`default_nettype wire
